// ==== shared/mrp_pkg.sv ====
// Shared constants and types for the memory request port interface
package mrp_pkg;

  // ------------------------------------------------------------------
  // Link and port widths
  // ------------------------------------------------------------------
  localparam int PORTS     = 2;
  localparam int ADDR_W    = 48;
  localparam int DATA_W    = 64;
  localparam int CTL_W     = 32;
  localparam int SIZE_W    = 2;
  localparam int OFF_W     = 3;
  localparam int CMD_W     = 2;
  localparam int LINK_MHZ  = 300;
  localparam int PORT_MHZ  = 150;

  // ------------------------------------------------------------------
  // Request commands and sizes
  // ------------------------------------------------------------------
  localparam logic [CMD_W-1:0]  CMD_LOAD   = 2'h0;
  localparam logic [CMD_W-1:0]  CMD_STORE  = 2'h1;
  localparam logic [CMD_W-1:0]  CMD_FENCE  = 2'h2;
  localparam logic [SIZE_W-1:0] SIZE_BYTE  = 2'h0;
  localparam logic [SIZE_W-1:0] SIZE_WORD  = 2'h1;
  localparam logic [SIZE_W-1:0] SIZE_DWORD = 2'h2;
  localparam logic [SIZE_W-1:0] SIZE_QWORD = 2'h3;

  // ------------------------------------------------------------------
  // Request queue entry layout
  // ------------------------------------------------------------------
  localparam int E_DATA_LSB = 0;
  localparam int E_ADDR_LSB = E_DATA_LSB + DATA_W;
  localparam int E_SIZE_LSB = E_ADDR_LSB + ADDR_W;
  localparam int E_CMD_LSB  = E_SIZE_LSB + SIZE_W;
  localparam int ENT_W      = E_CMD_LSB + CMD_W;

  // ------------------------------------------------------------------
  // Read control entry layout
  // ------------------------------------------------------------------
  localparam int RC_CTL_LSB  = 0;
  localparam int RC_OFF_LSB  = RC_CTL_LSB + CTL_W;
  localparam int RC_PORT_BIT = RC_OFF_LSB + OFF_W;
  localparam int RC_W        = RC_PORT_BIT + 1;

  // ------------------------------------------------------------------
  // Timing counts in port clock cycles
  // ------------------------------------------------------------------
  localparam int REQ_STOP_CYCLES = 2;
  localparam int RSP_INFLIGHT    = 5;
  localparam int RSP_PIPE        = 2;
  localparam int MAX_FLUSH       = 4;
  localparam int FLUSH_W         = 3;

  // ------------------------------------------------------------------
  // Memory organisation and interleave
  // ------------------------------------------------------------------
  localparam int NUM_MC          = 8;
  localparam int DIMM_PER_MC     = 2;
  localparam int SUBBUS_PER_DIMM = 8;
  localparam int BANK_PER_SUBBUS = 8;
  localparam int NUM_BANKS = NUM_MC * DIMM_PER_MC * SUBBUS_PER_DIMM * BANK_PER_SUBBUS;
  localparam logic IL_BINARY = 1'b0;
  localparam logic IL_3131   = 1'b1;

  // Arbitration turn between even and odd ports
  typedef enum logic [1:0] {
    TURN_EVEN = 2'b01,
    TURN_ODD  = 2'b10
  } mrp_turn_t;

endpackage : mrp_pkg

// ==== hw/mrp_ctl_ram.sv ====
// Read control buffer memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module mrp_ctl_ram #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 16
) (
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage write
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : mrp_ctl_ram
`default_nettype wire

// ==== hw/mrp_mem_port.sv ====
// Memory request port interface: even/odd ports merged onto one link
// Notes on behaviour
// R1: Two request ports, even and odd, merge onto one shared link channel.
// R2: Store data waits in a FIFO until sent; stores never get responses.
// R3: Load control word queues, then moves to a buffer indexed by transaction id.
// R4: Load response returns low 32 bits of the request's control word.
// R5: Personality issues at most one request per cycle, not while stalled.
// R6: Load, store and fence strobes; fences are handled without personality help.
// R7: Size, address and data are valid with the load or store strobe.
// R8: Narrow stores sit in byte lanes chosen by address offset.
// R9: Narrow stores may be replicated; address stays naturally aligned.
// R10: Personality places a unique tag in low 32 control bits of loads.
// R11: Personality stops a stalled request type within two cycles.
// R12: Responses only for loads, on even or odd response port.
// R13: Load data is right-justified to byte 0 whatever the offset.
// R14: One response per push; up to five more may follow a stall.
// R15: Loads and stores may complete out of issue order.
// R16: A fence lets nothing pass until all earlier requests complete.
// R17: Personality orders same-location accesses via flush or read response.
// R18: Flush completes with a one-cycle pulse after the port's stores finish.
// R19: Personality flushes every port with pending stores and awaits all.
// R20: Personality keeps at most four flushes outstanding per port.
// R21: Memory is eight controllers, two DIMMs, eight sub-buses, eight banks.
// R22: Interleave mode is binary or 31-31, fixed at boot.
// R23: Personality routes each address only to its owning interface.
// R24: Personality asserts at most one request strobe per port per cycle.
`timescale 1ns/100ps
`default_nettype none
module mrp_mem_port #(
  parameter int FIFO_DEPTH = 8,
  parameter int NUM_TID    = 16,
  parameter int OUT_W      = 16
) (
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  input  wire logic                       load_request_e,
  input  wire logic                       store_request_e,
  input  wire logic                       fence_request_e,
  input  wire logic                       flush_request_e,
  input  wire logic [mrp_pkg::SIZE_W-1:0] request_size_e,
  input  wire logic [mrp_pkg::ADDR_W-1:0] request_address_e,
  input  wire logic [mrp_pkg::DATA_W-1:0] write_data_read_control_e,
  output logic                            read_request_stall_e,
  output logic                            write_request_stall_e,
  output logic                            response_push_e,
  output logic      [mrp_pkg::DATA_W-1:0] response_data_e,
  output logic      [mrp_pkg::CTL_W-1:0]  response_read_control_e,
  input  wire logic                       response_stall_e,
  output logic                            flush_complete_e,
  input  wire logic                       load_request_o,
  input  wire logic                       store_request_o,
  input  wire logic                       fence_request_o,
  input  wire logic                       flush_request_o,
  input  wire logic [mrp_pkg::SIZE_W-1:0] request_size_o,
  input  wire logic [mrp_pkg::ADDR_W-1:0] request_address_o,
  input  wire logic [mrp_pkg::DATA_W-1:0] write_data_read_control_o,
  output logic                            read_request_stall_o,
  output logic                            write_request_stall_o,
  output logic                            response_push_o,
  output logic      [mrp_pkg::DATA_W-1:0] response_data_o,
  output logic      [mrp_pkg::CTL_W-1:0]  response_read_control_o,
  input  wire logic                       response_stall_o,
  output logic                            flush_complete_o,
  output logic                            link_req_valid,
  output logic      [mrp_pkg::CMD_W-1:0]  link_req_cmd,
  output logic                            link_req_port,
  output logic      [$clog2(NUM_TID)-1:0] link_req_tid,
  output logic      [mrp_pkg::SIZE_W-1:0] link_req_size,
  output logic      [mrp_pkg::ADDR_W-1:0] link_req_addr,
  output logic      [mrp_pkg::DATA_W-1:0] link_req_data,
  input  wire logic                       link_req_stall,
  input  wire logic                       link_wr_done,
  input  wire logic                       link_wr_done_port,
  input  wire logic                       link_rsp_valid,
  input  wire logic [$clog2(NUM_TID)-1:0] link_rsp_tid,
  input  wire logic [mrp_pkg::DATA_W-1:0] link_rsp_data,
  output logic                            link_rsp_stall,
  input  wire logic                       interleave_select,
  output logic                            link_interleave
);

  localparam int PTR_W = $clog2(FIFO_DEPTH);
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam int TID_W = $clog2(NUM_TID);
  localparam logic [CNT_W-1:0] STALL_AT =
    CNT_W'(FIFO_DEPTH - 1 - mrp_pkg::REQ_STOP_CYCLES);

  // ------------------------------------------------------------------
  // Port gathering
  // ------------------------------------------------------------------
  logic [1:0]                       ld, st, fn, fl;
  logic [1:0][mrp_pkg::SIZE_W-1:0]  rq_size;
  logic [1:0][mrp_pkg::ADDR_W-1:0]  rq_addr;
  logic [1:0][mrp_pkg::DATA_W-1:0]  rq_data;
  logic [mrp_pkg::ENT_W-1:0]        fifo_mem [2][FIFO_DEPTH];
  logic [1:0][PTR_W-1:0]            wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0][CNT_W-1:0]            cnt_r, cnt_nxt;
  logic [1:0][OUT_W-1:0]            stq_r, stq_nxt, stl_r, stl_nxt, ldl_r, ldl_nxt;
  logic [1:0][mrp_pkg::FLUSH_W-1:0] flp_r, flp_nxt;
  logic [1:0]                       fc_r, fc_nxt, push_r, push_nxt;
  logic [1:0][mrp_pkg::DATA_W-1:0]  rdata_r, rdata_nxt;
  logic [1:0][mrp_pkg::CTL_W-1:0]   rctl_r, rctl_nxt;
  logic [1:0]                       enq, head_v, head_ld, head_st, head_fn;
  logic [1:0]                       can_go, grant, pop, fire, rsp_done, wstall;
  logic [1:0][mrp_pkg::ENT_W-1:0]   head;
  logic [1:0]                       wr_done_p;

  assign ld      = {load_request_o, load_request_e};
  assign st      = {store_request_o, store_request_e};
  assign fn      = {fence_request_o, fence_request_e};
  assign fl      = {flush_request_o, flush_request_e};
  assign rq_size = {request_size_o, request_size_e};
  assign rq_addr = {request_address_o, request_address_e};
  assign rq_data = {write_data_read_control_o, write_data_read_control_e};

  // ------------------------------------------------------------------
  // Transaction id pool
  // ------------------------------------------------------------------
  logic [NUM_TID-1:0] busy_r, busy_nxt;
  logic [TID_W-1:0]   free_tid;
  logic               tid_avail;
  logic               s1_valid_r;
  logic [TID_W-1:0]   s1_tid_r;
  logic [mrp_pkg::DATA_W-1:0] s1_data_r;
  logic [mrp_pkg::RC_W-1:0]   rc_rd;
  logic               ld_grant;

  // Lowest free id
  always_comb begin
    free_tid = '0;
    for (int i = NUM_TID - 1; i >= 0; i--) begin
      if (!busy_r[i]) begin
        free_tid = TID_W'(i);
      end
    end
  end
  assign tid_avail = ~&busy_r;
  assign ld_grant  = |(grant & head_ld);

  // Allocate on load issue, release on response delivery
  always_comb begin
    busy_nxt = busy_r;
    if (s1_valid_r) begin
      busy_nxt[s1_tid_r] = 1'b0;
    end
    if (ld_grant) begin
      busy_nxt[free_tid] = 1'b1;  // R3
    end
  end

  // ------------------------------------------------------------------
  // Per-port request queue, counters and flush tracking
  // ------------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < mrp_pkg::PORTS; p++) begin : g_port
      assign enq[p]     = ld[p] | st[p] | fn[p];
      assign head[p]    = fifo_mem[p][rp_r[p]];
      assign head_v[p]  = cnt_r[p] != '0;
      assign head_ld[p] = head_v[p] &&
        head[p][mrp_pkg::E_CMD_LSB +: mrp_pkg::CMD_W] == mrp_pkg::CMD_LOAD;
      assign head_st[p] = head_v[p] &&
        head[p][mrp_pkg::E_CMD_LSB +: mrp_pkg::CMD_W] == mrp_pkg::CMD_STORE;
      assign head_fn[p] = head_v[p] &&
        head[p][mrp_pkg::E_CMD_LSB +: mrp_pkg::CMD_W] == mrp_pkg::CMD_FENCE;
      // Fence waits until every earlier request on this port is done
      assign can_go[p]  = head_fn[p] ? (ldl_r[p] == '0 && stl_r[p] == '0) :  // R16
                          head_ld[p] ? tid_avail : head_st[p];
      assign pop[p]     = grant[p] | (head_fn[p] & can_go[p]);  // R6
      assign wr_done_p[p] = link_wr_done && (link_wr_done_port == 1'(p));
      assign rsp_done[p]  = s1_valid_r && (rc_rd[mrp_pkg::RC_PORT_BIT] == 1'(p));
      assign fire[p]    = flp_r[p] != '0 && stq_r[p] == '0 && stl_r[p] == '0;  // R18
      assign wstall[p]  = cnt_r[p] >= STALL_AT;  // R11

      // Next queue and counter state
      always_comb begin
        wp_nxt[p]  = wp_r[p] + PTR_W'(enq[p]);
        rp_nxt[p]  = rp_r[p] + PTR_W'(pop[p]);
        cnt_nxt[p] = cnt_r[p] + CNT_W'(enq[p]) - CNT_W'(pop[p]);
        stq_nxt[p] = stq_r[p] + OUT_W'(st[p]) - OUT_W'(grant[p] & head_st[p]);  // R2
        stl_nxt[p] = stl_r[p] + OUT_W'(grant[p] & head_st[p]) - OUT_W'(wr_done_p[p]);
        ldl_nxt[p] = ldl_r[p] + OUT_W'(grant[p] & head_ld[p]) - OUT_W'(rsp_done[p]);
        flp_nxt[p] = flp_r[p] + mrp_pkg::FLUSH_W'(fl[p])
                   - mrp_pkg::FLUSH_W'(fire[p]);
        fc_nxt[p]  = fire[p];
      end

      // Queue storage: loads carry their control word here too
      always_ff @(posedge ref_clk) begin
        if (enq[p]) begin
          fifo_mem[p][wp_r[p]] <= {(ld[p] ? mrp_pkg::CMD_LOAD :  // R3
                                    st[p] ? mrp_pkg::CMD_STORE : mrp_pkg::CMD_FENCE),
                                   rq_size[p], rq_addr[p], rq_data[p]};  // R2
        end
      end
    end
  endgenerate

  assign write_request_stall_e = wstall[0];
  assign write_request_stall_o = wstall[1];
  assign read_request_stall_e  = wstall[0] | ~tid_avail;
  assign read_request_stall_o  = wstall[1] | ~tid_avail;

  // ------------------------------------------------------------------
  // Link arbitration between even and odd ports
  // ------------------------------------------------------------------
  mrp_pkg::mrp_turn_t turn_r, turn_nxt;
  logic [1:0]         want;
  logic               gp;

  assign want = can_go & ~head_fn & {2{~link_req_stall}};
  assign gp   = grant[1];

  // One grant per cycle, alternating when both ports are ready
  always_comb begin
    grant = 2'b00;
    unique case (turn_r)
      mrp_pkg::TURN_EVEN: begin
        grant = want[0] ? 2'b01 : {want[1], 1'b0};  // R1
      end
      mrp_pkg::TURN_ODD: begin
        grant = want[1] ? 2'b10 : {1'b0, want[0]};  // R1
      end
    endcase
    turn_nxt = grant[0] ? mrp_pkg::TURN_ODD :
               grant[1] ? mrp_pkg::TURN_EVEN : turn_r;
  end

  // ------------------------------------------------------------------
  // Read control buffer and response path
  // ------------------------------------------------------------------
  logic [mrp_pkg::OFF_W-1:0]  s1_off;
  logic [mrp_pkg::DATA_W-1:0] aligned;

  mrp_ctl_ram #(
    .WIDTH (mrp_pkg::RC_W),
    .DEPTH (NUM_TID)
  ) u_ctl_ram (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .wr_en   (ld_grant),
    .wr_addr (free_tid),
    .wr_data ({gp, head[gp][mrp_pkg::E_ADDR_LSB +: mrp_pkg::OFF_W],
               head[gp][mrp_pkg::E_DATA_LSB +: mrp_pkg::CTL_W]}),  // R3
    .rd_addr (link_rsp_tid),
    .rd_data (rc_rd)
  );

  assign s1_off  = rc_rd[mrp_pkg::RC_OFF_LSB +: mrp_pkg::OFF_W];
  assign aligned = s1_data_r >> {s1_off, 3'h0};  // R13
  assign link_rsp_stall = response_stall_e | response_stall_o;  // R14

  // Deliver each response on the port that issued its load
  always_comb begin
    for (int i = 0; i < mrp_pkg::PORTS; i++) begin
      push_nxt[i]  = rsp_done[i];  // R12
      rdata_nxt[i] = rsp_done[i] ? aligned : rdata_r[i];
      rctl_nxt[i]  = rsp_done[i] ? rc_rd[mrp_pkg::RC_CTL_LSB +: mrp_pkg::CTL_W]  // R4
                                 : rctl_r[i];
    end
  end

  assign response_push_e         = push_r[0];
  assign response_push_o         = push_r[1];
  assign response_data_e         = rdata_r[0];
  assign response_data_o         = rdata_r[1];
  assign response_read_control_e = rctl_r[0];
  assign response_read_control_o = rctl_r[1];
  assign flush_complete_e        = fc_r[0];
  assign flush_complete_o        = fc_r[1];

  // ------------------------------------------------------------------
  // Boot-time interleave capture
  // ------------------------------------------------------------------
  logic il_r, il_nxt, il_lock_r;

  // Banks that the captured interleave mode spreads requests over
  localparam int BANKS = mrp_pkg::NUM_BANKS;  // R21

  // Sampled once after reset release, then frozen
  always_comb begin
    il_nxt = il_lock_r ? il_r : interleave_select;  // R22
  end
  assign link_interleave = il_r;

  // ------------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      stq_r <= '0;
      stl_r <= '0;
      ldl_r <= '0;
      flp_r <= '0;
      fc_r <= '0;
      push_r <= '0;
      rdata_r <= '0;
      rctl_r <= '0;
      busy_r <= '0;
      turn_r <= mrp_pkg::TURN_EVEN;
      s1_valid_r <= 1'b0;
      s1_tid_r <= '0;
      s1_data_r <= '0;
      il_r <= mrp_pkg::IL_BINARY;
      il_lock_r <= 1'b0;
      link_req_valid <= 1'b0;
      link_req_cmd <= '0;
      link_req_port <= 1'b0;
      link_req_tid <= '0;
      link_req_size <= '0;
      link_req_addr <= '0;
      link_req_data <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      stq_r <= stq_nxt;
      stl_r <= stl_nxt;
      ldl_r <= ldl_nxt;
      flp_r <= flp_nxt;
      fc_r <= fc_nxt;
      push_r <= push_nxt;
      rdata_r <= rdata_nxt;
      rctl_r <= rctl_nxt;
      busy_r <= busy_nxt;
      turn_r <= turn_nxt;
      s1_valid_r <= link_rsp_valid;  // R15
      s1_tid_r <= link_rsp_tid;
      s1_data_r <= link_rsp_data;
      il_r <= il_nxt;
      il_lock_r <= 1'b1;
      link_req_valid <= |grant;  // R1
      link_req_cmd <= head[gp][mrp_pkg::E_CMD_LSB +: mrp_pkg::CMD_W];
      link_req_port <= gp;
      link_req_tid <= free_tid;
      link_req_size <= head[gp][mrp_pkg::E_SIZE_LSB +: mrp_pkg::SIZE_W];
      link_req_addr <= head[gp][mrp_pkg::E_ADDR_LSB +: mrp_pkg::ADDR_W];
      link_req_data <= head[gp][mrp_pkg::E_DATA_LSB +: mrp_pkg::DATA_W];
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_merge_one_grant: assert property ($onehot0(grant))  // R1
    else $error("both ports granted in one cycle");
  a_no_store_rsp: assert property (response_push_e |-> $past(ldl_r[0] != '0))  // R2
    else $error("even response without an outstanding load");
  a_tid_alloc_free: assert property (ld_grant |-> !busy_r[free_tid])  // R3
    else $error("load issued on a busy transaction id");
  a_rsp_latency: assert property (link_rsp_valid |-> ##2 (response_push_e ^ response_push_o))  // R12
    else $error("link response not delivered two cycles later");
  a_align_byte0: assert property (response_push_o |->
      response_data_o == ($past(s1_data_r) >> {$past(s1_off), 3'h0}))  // R13
    else $error("odd response data not right-justified");
  a_ctl_return: assert property (response_push_e |->
      response_read_control_e == $past(rc_rd[mrp_pkg::CTL_W-1:0]))  // R4
    else $error("even response control word mismatch");
  a_fence_drained: assert property (head_fn[0] && pop[0] |->
      ldl_r[0] == '0 && stl_r[0] == '0 && !grant[0])  // R16
    else $error("fence passed with requests outstanding");
  a_flush_after_stores: assert property (flush_complete_o |->
      $past(stq_r[1] == '0 && stl_r[1] == '0 && flp_r[1] != '0))  // R18
    else $error("odd flush completed with stores pending");
  a_interleave_fixed: assert property (il_lock_r |=> $stable(link_interleave))  // R22
    else $error("interleave mode changed after boot");

endmodule : mrp_mem_port
`default_nettype wire

// ==== verif/mrp_link_model.sv ====
// Link side model: answers loads and stores after a fixed delay
`timescale 1ns/100ps
`default_nettype none
module mrp_link_model #(
  parameter logic [63:0] MEM_WORD = 64'h8877665544332211,
  parameter int          NUM_TID  = 16
) (
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  input  wire logic                       link_req_valid,
  input  wire logic [1:0]                 link_req_cmd,
  input  wire logic                       link_req_port,
  input  wire logic [$clog2(NUM_TID)-1:0] link_req_tid,
  output logic                            link_wr_done,
  output logic                            link_wr_done_port,
  output logic                            link_rsp_valid,
  output logic      [$clog2(NUM_TID)-1:0] link_rsp_tid,
  output logic      [63:0]                link_rsp_data
);
  logic [7:0] pipe_r [0:2];

  // Three stage delay line of issued requests
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pipe_r <= '{default: '0};
    end else begin
      pipe_r[0] <= {link_req_valid, link_req_cmd, link_req_port, link_req_tid};
      pipe_r[1] <= pipe_r[0];
      pipe_r[2] <= pipe_r[1];
    end
  end

  // Replies; data line shows inverse when idle
  assign link_rsp_valid    = pipe_r[2][7] && pipe_r[2][6:5] == mrp_pkg::CMD_LOAD;
  assign link_wr_done      = pipe_r[2][7] && pipe_r[2][6:5] == mrp_pkg::CMD_STORE;
  assign link_wr_done_port = pipe_r[2][4];
  assign link_rsp_tid      = pipe_r[2][3:0];
  assign link_rsp_data     = link_rsp_valid ? MEM_WORD : ~MEM_WORD;
endmodule : mrp_link_model
`default_nettype wire

// ==== verif/tb_mrp_mem_port.sv ====
// Self-checking bench for the memory request port interface
`timescale 1ns/100ps
`default_nettype none
module tb_mrp_mem_port;
  localparam logic [63:0] MEM = 64'h8877665544332211;
  logic ref_clk = 1'b0, reset_n = 1'b0, il_sel = 1'b1, lk_stall = 1'b0, rs_e = 1'b0, rs_o = 1'b0;
  logic ld_e = 1'b0, st_e = 1'b0, fn_e = 1'b0, fl_e = 1'b0, ld_o = 1'b0, st_o = 1'b0;
  logic fn_o = 1'b0, fl_o = 1'b0, sport;
  logic [1:0] sz_e = '0, sz_o = '0, lcmd, lsz, scmd, ssz;
  logic [47:0] ad_e = '0, ad_o = '0, ladr, sadr;
  logic [7:0] lt;
  logic [63:0] wd_e = '0, wd_o = '0, rd_e, rd_o, ldat, lrd, cd_e, cd_o, sdat;
  logic rrs_e, wrs_e, push_e, fc_e, rrs_o, wrs_o, push_o, fc_o, lv, lp, lwd, lwp, lrv, lrs, lil;
  logic [31:0] rc_e, rc_o, cc_e, cc_o;
  logic [3:0] ltid, lrt;
  int n_fail = 0, checks = 0, np_e = 0, np_o = 0, nf_e = 0, nf_o = 0, nl = 0;

  mrp_mem_port mrp_mem_port_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .load_request_e(ld_e), .store_request_e(st_e), .fence_request_e(fn_e),
    .flush_request_e(fl_e), .request_size_e(sz_e), .request_address_e(ad_e),
    .write_data_read_control_e(wd_e), .read_request_stall_e(rrs_e),
    .write_request_stall_e(wrs_e), .response_push_e(push_e), .response_data_e(rd_e),
    .response_read_control_e(rc_e), .response_stall_e(rs_e), .flush_complete_e(fc_e),
    .load_request_o(ld_o), .store_request_o(st_o), .fence_request_o(fn_o),
    .flush_request_o(fl_o), .request_size_o(sz_o), .request_address_o(ad_o),
    .write_data_read_control_o(wd_o), .read_request_stall_o(rrs_o),
    .write_request_stall_o(wrs_o), .response_push_o(push_o), .response_data_o(rd_o),
    .response_read_control_o(rc_o), .response_stall_o(rs_o), .flush_complete_o(fc_o),
    .link_req_valid(lv), .link_req_cmd(lcmd), .link_req_port(lp), .link_req_tid(ltid),
    .link_req_size(lsz), .link_req_addr(ladr), .link_req_data(ldat),
    .link_req_stall(lk_stall), .link_wr_done(lwd), .link_wr_done_port(lwp),
    .link_rsp_valid(lrv), .link_rsp_tid(lrt), .link_rsp_data(lrd),
    .link_rsp_stall(lrs), .interleave_select(il_sel), .link_interleave(lil));

  mrp_link_model mrp_link_model_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .link_req_valid(lv), .link_req_cmd(lcmd), .link_req_port(lp), .link_req_tid(ltid),
    .link_wr_done(lwd), .link_wr_done_port(lwp), .link_rsp_valid(lrv),
    .link_rsp_tid(lrt), .link_rsp_data(lrd));

  // Clock
  always #12.5 ref_clk = ~ref_clk;

  // Record responses, flush pulses and stores on the link
  always @(posedge ref_clk) begin
    if (push_e) begin np_e++; cd_e = rd_e; cc_e = rc_e; end
    if (push_o) begin np_o++; cd_o = rd_o; cc_o = rc_o; end
    if (fc_e) nf_e++;
    if (fc_o) nf_o++;
    if (lv) nl++;
    if (lv && lcmd == mrp_pkg::CMD_LOAD) lt = {lt[3:0], ltid};
    if (lv && lcmd == mrp_pkg::CMD_STORE) begin
      scmd = lcmd; sport = lp; sdat = ldat; sadr = ladr; ssz = lsz;
    end
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Kind 0 load, 1 store, 2 fence, 3 flush
  task automatic put(input logic odd, input int k, input logic [1:0] sz,
                     input logic [47:0] a, input logic [63:0] d);
    if (odd) begin
      ld_o = k == 0; st_o = k == 1; fn_o = k == 2; fl_o = k == 3; sz_o = sz; ad_o = a; wd_o = d;
    end else begin
      ld_e = k == 0; st_e = k == 1; fn_e = k == 2; fl_e = k == 3; sz_e = sz; ad_e = a; wd_e = d;
    end
  endtask : put

  task automatic clr();
    @(negedge ref_clk);
    {ld_e, st_e, fn_e, fl_e, ld_o, st_o, fn_o, fl_o} = '0;
  endtask : clr

  task automatic settle();
    repeat (40) @(negedge ref_clk);
  endtask : settle

  task automatic t_loads();
    np_e = 0; np_o = 0;
    @(negedge ref_clk);
    put(1'b0, 0, mrp_pkg::SIZE_BYTE, 48'h1002, 64'hffff0000_000000ab);
    put(1'b1, 0, mrp_pkg::SIZE_QWORD, 48'h2000, 64'h5555aaaa_000000cd);
    clr();
    settle();
    chk(np_e, 1);
    chk(np_o, 1);
    chk(cd_e[7:0], MEM[23:16]);
    chk(cc_e, 32'h000000ab);
    chk(cd_o, MEM);
    chk(cc_o, 32'h000000cd);
    chk(lt, 8'h01);
  endtask : t_loads

  task automatic t_store_flush();
    np_o = 0; nf_o = 0;
    @(negedge ref_clk);
    put(1'b1, 1, mrp_pkg::SIZE_DWORD, 48'h3004, 64'h12345678_00000000);
    @(negedge ref_clk);
    put(1'b1, 3, mrp_pkg::SIZE_DWORD, 48'h3004, 64'h0);
    clr();
    settle();
    chk(scmd, mrp_pkg::CMD_STORE);
    chk(sadr, 48'h3004);
    chk(ssz, mrp_pkg::SIZE_DWORD);
    chk(sport, 1'b1);
    chk(sdat, 64'h12345678_00000000);
    chk(np_o, 0);
    chk(nf_o, 1);
  endtask : t_store_flush

  task automatic t_stall();
    nf_e = 0;
    nl = 0;
    lk_stall = 1'b1;
    rs_e = 1'b1;
    repeat (5) begin
      @(negedge ref_clk);
      put(1'b0, 1, mrp_pkg::SIZE_WORD, 48'h4000, 64'h1234123412341234);
    end
    @(negedge ref_clk);
    chk(wrs_e, 1'b1);
    chk(rrs_e, 1'b1);
    chk(wrs_o, 1'b0);
    chk(lrs, 1'b1);
    lk_stall = 1'b0;
    rs_e = 1'b0;
    put(1'b0, 3, mrp_pkg::SIZE_QWORD, 48'h4000, 64'h0);
    @(negedge ref_clk);
    put(1'b0, 2, mrp_pkg::SIZE_QWORD, 48'h4000, 64'h0);
    clr();
    settle();
    chk(wrs_e, 1'b0);
    chk(nf_e, 1);
    chk(nl, 5);
  endtask : t_stall

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    repeat (6) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    il_sel = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(lil, 1'b1);
    t_loads();
    t_store_flush();
    t_stall();
    print_verdict();
  end

  // Watchdog
  initial begin
    repeat (2000) @(posedge ref_clk);
    n_fail++;
    print_verdict();
  end
endmodule : tb_mrp_mem_port
`default_nettype wire
